// *** verilog/lcdsc_top.sv ***
// serial command receiver, display byte router and command_a control
`timescale 1ns/100ps
`include "lcdsc_regs.svh"
// How it works
// - normal mode command_a divisors 92160, 184320, 368640
// - power-saving command_a divisors 15360, 30720, 61440
// - whole display blinks at rate, off means none
// - alternation swaps banks in static, 1:2
// - no bank alternation in 1:3, 1:4
// - sda falls while scl high: start
// - sda rises while scl high: stop, ends transfer
// - ninth clock after each byte is acknowledge
// - acknowledge holds sda low through scl high
// - receive only; sda driven only to acknowledge
// - hold scl low until pending byte stored
// - address 011100x, low bit equals strap
// - strap mismatch ignores all until the next start or stop
// - every addressed device acknowledges command bytes
// - command msb set: another command follows
// - display byte at pointer; pointer advances, subaddress on overflow
// - only matching subaddress acknowledges display data
// - command_a command: two-bit rate, alternation bit
// - mode command: display enable and low power
// - mismatched subaddress: drop byte, still advance
module lcdsc_top #(
  parameter int DIV_N_2HZ = `LCDSC_DIV_N_2HZ,
  parameter int DIV_N_1HZ = `LCDSC_DIV_N_1HZ,
  parameter int DIV_N_05HZ = `LCDSC_DIV_N_05HZ,
  parameter int DIV_P_2HZ = `LCDSC_DIV_P_2HZ,
  parameter int DIV_P_1HZ = `LCDSC_DIV_P_1HZ,
  parameter int DIV_P_05HZ = `LCDSC_DIV_P_05HZ
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDRESS_SELECT_STRAP,
  input wire logic HW_SUBADDR_BIT0,
  input wire logic HW_SUBADDR_BIT1,
  input wire logic HW_SUBADDR_BIT2,
  output logic WR_VALID,
  input wire logic WR_READY,
  output logic [7:0] WR_DATA,
  output logic [5:0] WR_ADDR,
  output logic WR_IN_BANK,
  output logic [1:0] WR_MODE,
  output logic [1:0] DRIVE_MODE,
  output logic BIAS_HALF,
  output logic LOW_POWER_SELECT,
  output logic DISPLAY_ON,
  output logic OUT_BANK_SEL
);
  localparam logic [5:0] PIN_RST = `LCDSC_PIN_RST; // bus lines idle high

  // pin synchronisers: scl, sda, strap, subaddress
  logic [5:0] pin_w; // raw pins
  logic [5:0] s1_q; // first stage, read only by the second
  logic [5:0] s2_q; // second stage
  logic [5:0] s3_q; // third stage
  logic [5:0] lvl_q; // accepted levels
  logic scl_p_q; // scl one cycle back
  logic sda_p_q; // sda one cycle back

  // receiver state
  lcdsc_pkg::lcdsc_state_t st_q; // byte level state
  lcdsc_pkg::lcdsc_state_t st_nxt_w; // state after this byte
  logic [7:0] sh_q; // incoming byte
  logic [3:0] bit_q; // bits received
  logic ack_q; // inside the acknowledge slot
  logic sda_oe_q; // pulling sda low
  logic scl_oe_q; // pulling scl low

  // configuration set by commands
  lcdsc_pkg::lcdsc_mode_t mode_q; // drive mode
  logic lp_q; // power-saving mode
  logic en_q; // display enable
  logic bias_q; // half bias
  logic [5:0] ptr_q; // data pointer
  logic [2:0] sub_q; // subaddress counter
  logic ibank_q; // input bank
  logic obank_q; // output bank
  logic [1:0] rate_q; // command_a rate
  logic alt_q; // alternation blinking

  // pending display byte and outputs
  logic [16:0] pend_q; // byte, address, bank, mode
  logic pend_v_q; // pending byte not yet buffered
  logic disp_on_q; // registered display on
  logic obank_eff_q; // registered output bank

  // decode wires
  logic scl_w;
  logic sda_w;
  logic strap_w;
  logic [2:0] hw_sub_w;
  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;
  logic active_w;
  logic byte_done_w;
  logic addr_hit_w;
  logic sub_hit_w;
  logic ack_w;
  logic cmd_w;
  logic data_w;
  logic is_mode_w;
  logic is_ldp_w;
  logic is_dev_w;
  logic is_bank_w;
  logic is_command_a_w;
  logic bankable_w;
  logic [6:0] inc_w;
  logic [6:0] sum_w;
  logic wrap_w;
  logic [5:0] ptr_nxt_w;
  logic buf_in_ready_w;
  logic push_w;
  logic [16:0] buf_out_w;
  logic blank_w;
  logic swap_w;

  assign pin_w = {HW_SUBADDR_BIT2, HW_SUBADDR_BIT1, HW_SUBADDR_BIT0, ADDRESS_SELECT_STRAP, SDA_IN, SCL_IN};

  // three synchroniser flops and a level flop per pin; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          s1_q[g] <= PIN_RST[g];
          s2_q[g] <= PIN_RST[g];
          s3_q[g] <= PIN_RST[g];
          lvl_q[g] <= PIN_RST[g];
        end else begin
          s1_q[g] <= pin_w[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  // previous levels for edge detection
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_w;
      sda_p_q <= sda_w;
    end
  end

  assign scl_w = lvl_q[0];
  assign sda_w = lvl_q[1];
  assign strap_w = lvl_q[2];
  assign hw_sub_w = lvl_q[5:3];
  assign scl_rise_w = scl_w & ~scl_p_q;
  assign scl_fall_w = ~scl_w & scl_p_q;
  // start and stop are sda edges with scl steady high
  assign start_w = scl_w & scl_p_q & sda_p_q & ~sda_w;
  assign stop_w = scl_w & scl_p_q & ~sda_p_q & sda_w;
  assign active_w = (st_q == lcdsc_pkg::ST_ADDR) | (st_q == lcdsc_pkg::ST_CMD) | (st_q == lcdsc_pkg::ST_DATA);
  // eighth bit sampled and scl falls: the acknowledge slot opens
  assign byte_done_w = scl_fall_w & ~ack_q & (bit_q == 4'h8) & active_w;
  // write address with the strap as low bit; a read request is not ours
  assign addr_hit_w = (sh_q[7:1] == {`LCDSC_ADDR_HI, strap_w}) & ~sh_q[0];
  assign sub_hit_w = (sub_q == hw_sub_w);
  // who acknowledges which byte
  assign ack_w = ((st_q == lcdsc_pkg::ST_ADDR) & addr_hit_w) | (st_q == lcdsc_pkg::ST_CMD)
               | ((st_q == lcdsc_pkg::ST_DATA) & sub_hit_w);
  assign cmd_w = byte_done_w & (st_q == lcdsc_pkg::ST_CMD);
  assign data_w = byte_done_w & (st_q == lcdsc_pkg::ST_DATA);

  // command decode below the continuation bit
  assign is_mode_w = (sh_q[6:5] == `LCDSC_OP_MODE);
  assign is_ldp_w = ~sh_q[6];
  assign is_dev_w = (sh_q[6:3] == `LCDSC_OP_DEVSEL);
  assign is_bank_w = (sh_q[6:2] == `LCDSC_OP_BANK);
  assign is_command_a_w = (sh_q[6:3] == `LCDSC_OP_COMMAND_A);

  // pointer step follows drive mode; overflow wraps into the next subaddress
  assign bankable_w = (mode_q == `LCDSC_M_STATIC) | (mode_q == `LCDSC_M_MUX2);
  assign inc_w = (mode_q == `LCDSC_M_STATIC) ? `LCDSC_INC_STATIC : (mode_q == `LCDSC_M_MUX2) ? `LCDSC_INC_MUX2
               : (mode_q == `LCDSC_M_MUX3) ? `LCDSC_INC_MUX3 : `LCDSC_INC_MUX4;
  assign sum_w = {1'b0, ptr_q} + inc_w;
  assign wrap_w = (sum_w >= `LCDSC_RAM_WORDS);
  assign ptr_nxt_w = wrap_w ? 6'(sum_w - `LCDSC_RAM_WORDS) : sum_w[5:0];
  assign push_w = pend_v_q & buf_in_ready_w;

  // state after the current byte
  always_comb begin
    unique case (st_q)
      lcdsc_pkg::ST_ADDR: st_nxt_w = addr_hit_w ? lcdsc_pkg::ST_CMD : lcdsc_pkg::ST_IGNORE;
      lcdsc_pkg::ST_CMD: st_nxt_w = sh_q[7] ? lcdsc_pkg::ST_CMD : lcdsc_pkg::ST_DATA;
      lcdsc_pkg::ST_DATA: st_nxt_w = lcdsc_pkg::ST_DATA;
      lcdsc_pkg::ST_IGNORE: st_nxt_w = lcdsc_pkg::ST_IGNORE;
      lcdsc_pkg::ST_IDLE: st_nxt_w = lcdsc_pkg::ST_IDLE;
      default: st_nxt_w = lcdsc_pkg::ST_IDLE;
    endcase
  end

  // bit shifting, acknowledge slot and transfer framing
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_q <= lcdsc_pkg::ST_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_w | stop_w) begin
      // start opens an address byte, stop returns to idle
      st_q <= start_w ? lcdsc_pkg::ST_ADDR : lcdsc_pkg::ST_IDLE;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (scl_rise_w & ~ack_q & (bit_q != 4'h8) & active_w) begin
      // sample one bit per scl pulse, msb first
      sh_q <= {sh_q[6:0], sda_w};
      bit_q <= bit_q + 4'h1;
    end else if (byte_done_w) begin
      // drive low only for an acknowledge, never to send data
      ack_q <= 1'b1;
      sda_oe_q <= ack_w;
      st_q <= st_nxt_w;
    end else if (scl_fall_w & ack_q) begin
      // acknowledge pulse over, release sda
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      bit_q <= 4'h0;
    end
  end

  // command execution and pointer update
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode_q <= `LCDSC_RST_MODE;
      lp_q <= 1'b0;
      en_q <= 1'b0;
      bias_q <= 1'b0;
      ptr_q <= 6'h00;
      sub_q <= 3'h0;
      ibank_q <= 1'b0;
      obank_q <= 1'b0;
      rate_q <= `LCDSC_RATE_OFF;
      alt_q <= 1'b0;
    end else if (cmd_w) begin
      if (is_mode_w) begin
        // enable and power-saving bits
        lp_q <= sh_q[4];
        en_q <= sh_q[3];
        bias_q <= sh_q[2];
        mode_q <= sh_q[1:0];
      end
      if (is_ldp_w) begin
        ptr_q <= sh_q[5:0];
      end
      if (is_dev_w) begin
        sub_q <= sh_q[2:0];
      end
      if (is_bank_w) begin
        ibank_q <= sh_q[1];
        obank_q <= sh_q[0];
      end
      if (is_command_a_w) begin
        // rate field and alternation bit
        alt_q <= sh_q[2];
        rate_q <= sh_q[1:0];
      end
    end else if (data_w) begin
      // pointer moves whether or not the byte is ours
      ptr_q <= ptr_nxt_w;
      sub_q <= sub_q + {2'h0, wrap_w};
    end
  end

  // pending byte capture; a new capture wins over the push that clears it
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pend_q <= 17'h00000;
      pend_v_q <= 1'b0;
    end else begin
      if (push_w) begin
        pend_v_q <= 1'b0;
      end
      if (data_w & sub_hit_w) begin
        // only the matching device stores
        pend_q <= {sh_q, ptr_q, ibank_q & bankable_w, mode_q};
        pend_v_q <= 1'b1;
      end
    end
  end

  // scl stretch: hold low from a fall until the pending byte is buffered
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= pend_v_q & ~push_w & (scl_oe_q | scl_fall_w);
    end
  end

  // registered display controls
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      disp_on_q <= 1'b0;
      obank_eff_q <= 1'b0;
    end else begin
      disp_on_q <= en_q & ~blank_w;
      obank_eff_q <= bankable_w & (obank_q ^ swap_w);
    end
  end

  // two-entry buffer toward the ram writer
  lcdsc_buf2 #(.W(17)) u_buf (
    .clk(CORE_CLK),
    .rst(RST),
    .in_valid(pend_v_q),
    .in_ready(buf_in_ready_w),
    .in_data(pend_q),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(buf_out_w)
  );

  // command_a generator
  lcdsc_blinker #(
    .DIV_N_2HZ(DIV_N_2HZ),
    .DIV_N_1HZ(DIV_N_1HZ),
    .DIV_N_05HZ(DIV_N_05HZ),
    .DIV_P_2HZ(DIV_P_2HZ),
    .DIV_P_1HZ(DIV_P_1HZ),
    .DIV_P_05HZ(DIV_P_05HZ)
  ) u_command_a (
    .clk(CORE_CLK),
    .rst(RST),
    .rate(rate_q),
    .alt(alt_q),
    .low_power(lp_q),
    .mode(mode_q),
    .blank(blank_w),
    .swap(swap_w)
  );

  // outputs; the pins only ever pull low
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = scl_oe_q;
  assign SDA_OE = sda_oe_q;
  assign WR_DATA = buf_out_w[16:9];
  assign WR_ADDR = buf_out_w[8:3];
  assign WR_IN_BANK = buf_out_w[2];
  assign WR_MODE = buf_out_w[1:0];
  assign DRIVE_MODE = mode_q;
  assign BIAS_HALF = bias_q;
  assign LOW_POWER_SELECT = lp_q;
  assign DISPLAY_ON = disp_on_q;
  assign OUT_BANK_SEL = obank_eff_q;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_start_opens_addr: assert property (start_w |=> st_q == lcdsc_pkg::ST_ADDR && bit_q == 4'h0)
    else $error("start did not open an address byte");
  chk_stop_ends_xfer: assert property (stop_w |=> st_q == lcdsc_pkg::ST_IDLE && !sda_oe_q)
    else $error("stop did not end the transfer");
  chk_ack_held_high: assert property (sda_oe_q && scl_w && !start_w && !stop_w |=> sda_oe_q)
    else $error("acknowledge released while scl high");
  chk_sda_only_ack: assert property (sda_oe_q |-> ack_q)
    else $error("sda driven outside acknowledge slot");
  chk_addr_ack: assert property (byte_done_w && st_q == lcdsc_pkg::ST_ADDR |=> sda_oe_q == $past(addr_hit_w))
    else $error("address acknowledge wrong");
  chk_ignore_silent: assert property (st_q == lcdsc_pkg::ST_IGNORE |-> !sda_oe_q && !pend_v_q)
    else $error("ignored transfer drove the bus");
  chk_data_ack_sub: assert property (data_w |=> sda_oe_q == $past(sub_hit_w) && pend_v_q == $past(sub_hit_w))
    else $error("display acknowledge ignores subaddress");
  chk_cmd_ack_all: assert property (cmd_w |=> sda_oe_q ##1 (sda_oe_q || !ack_q))
    else $error("command byte not acknowledged");
  chk_stretch_cause: assert property ($rose(scl_oe_q) |-> $past(pend_v_q) && !$past(buf_in_ready_w))
    else $error("scl held without a stalled byte");
  chk_ptr_advance: assert property (data_w && !wrap_w |=> ptr_q == $past(ptr_q) + $past(inc_w[5:0]))
    else $error("pointer did not advance");
  cov_data_ack: cover property (data_w && sub_hit_w);
  cov_stretch: cover property (scl_oe_q ##1 !scl_oe_q);
  cov_ignored: cover property (st_q == lcdsc_pkg::ST_IGNORE);
endmodule

// *** shared/lcdsc_regs.svh ***
// constants for the serial command front end and command_a generator
`ifndef LCDSC_REGS_SVH
`define LCDSC_REGS_SVH
// upper six bits of the seven-bit slave address, low bit is the strap
`define LCDSC_ADDR_HI 6'h1C
// command_a divisors, normal operating mode
`define LCDSC_DIV_N_2HZ 92160
`define LCDSC_DIV_N_1HZ 184320
`define LCDSC_DIV_N_05HZ 368640
// command_a divisors, power-saving mode
`define LCDSC_DIV_P_2HZ 15360
`define LCDSC_DIV_P_1HZ 30720
`define LCDSC_DIV_P_05HZ 61440
// command_a rate field codes
`define LCDSC_RATE_OFF 2'h0
`define LCDSC_RATE_2HZ 2'h1
`define LCDSC_RATE_1HZ 2'h2
// drive mode codes
`define LCDSC_M_STATIC 2'h1
`define LCDSC_M_MUX2 2'h2
`define LCDSC_M_MUX3 2'h3
`define LCDSC_M_MUX4 2'h0
// data pointer steps per display byte
`define LCDSC_INC_STATIC 7'h08
`define LCDSC_INC_MUX2 7'h04
`define LCDSC_INC_MUX3 7'h03
`define LCDSC_INC_MUX4 7'h02
// display ram words per device
`define LCDSC_RAM_WORDS 7'h28
// command opcode patterns below the continuation bit
`define LCDSC_OP_MODE 2'h2
`define LCDSC_OP_DEVSEL 4'hC
`define LCDSC_OP_BANK 5'h1E
`define LCDSC_OP_COMMAND_A 4'hE
// reset values
`define LCDSC_RST_MODE 2'h0
`define LCDSC_PIN_RST 6'h03
`endif

// *** shared/lcdsc_pkg.sv ***
// types shared by the serial front end
package lcdsc_pkg;
  // receiver states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_IGNORE} lcdsc_state_t;
  // drive mode field
  typedef logic [1:0] lcdsc_mode_t;
endpackage

// *** verilog/lcdsc_buf2.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module lcdsc_buf2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2]; // entry storage
  logic wp_q; // write slot
  logic rp_q; // read slot
  logic [1:0] cnt_q; // entries held
  logic wr_w;
  logic rd_w;

  // honest full and empty flags
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign wr_w = in_valid & in_ready;
  assign rd_w = out_valid & out_ready;

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (wr_w) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // slot pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q <= wp_q ^ wr_w;
      rp_q <= rp_q ^ rd_w;
      cnt_q <= 2'(cnt_q + {1'b0, wr_w} - {1'b0, rd_w});
    end
  end
endmodule

// *** verilog/lcdsc_blinker.sv ***
// command_a generator: divides the core clock to the command_a rate
`timescale 1ns/100ps
`include "lcdsc_regs.svh"
module lcdsc_blinker #(
  parameter int DIV_N_2HZ = `LCDSC_DIV_N_2HZ,
  parameter int DIV_N_1HZ = `LCDSC_DIV_N_1HZ,
  parameter int DIV_N_05HZ = `LCDSC_DIV_N_05HZ,
  parameter int DIV_P_2HZ = `LCDSC_DIV_P_2HZ,
  parameter int DIV_P_1HZ = `LCDSC_DIV_P_1HZ,
  parameter int DIV_P_05HZ = `LCDSC_DIV_P_05HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] rate,
  input wire logic alt,
  input wire logic low_power,
  input wire logic [1:0] mode,
  output logic blank,
  output logic swap
);
  // half periods minus one, the phase flips twice per command_a period
  localparam logic [18:0] HN2 = 19'(DIV_N_2HZ / 2 - 1);
  localparam logic [18:0] HN1 = 19'(DIV_N_1HZ / 2 - 1);
  localparam logic [18:0] HN05 = 19'(DIV_N_05HZ / 2 - 1);
  localparam logic [18:0] HP2 = 19'(DIV_P_2HZ / 2 - 1);
  localparam logic [18:0] HP1 = 19'(DIV_P_1HZ / 2 - 1);
  localparam logic [18:0] HP05 = 19'(DIV_P_05HZ / 2 - 1);

  logic [18:0] cnt_q; // cycles into the half period
  logic phase_q; // high during the off or swapped half
  logic [1:0] rate_q; // last rate, to restart on change
  logic lp_q; // last power mode
  logic [18:0] half_w;
  logic cfg_chg_w;
  logic on_w;
  logic bankable_w;

  // divisor choice by power mode and rate
  assign half_w = low_power ? ((rate == `LCDSC_RATE_2HZ) ? HP2 : (rate == `LCDSC_RATE_1HZ) ? HP1 : HP05)
                            : ((rate == `LCDSC_RATE_2HZ) ? HN2 : (rate == `LCDSC_RATE_1HZ) ? HN1 : HN05);
  assign cfg_chg_w = (rate != rate_q) | (low_power != lp_q);
  assign on_w = (rate != `LCDSC_RATE_OFF);
  // alternate banks exist only in static and 1:2 drive
  assign bankable_w = (mode == `LCDSC_M_STATIC) | (mode == `LCDSC_M_MUX2);
  // whole display blinks, or banks alternate
  assign blank = on_w & ~alt & phase_q;
  assign swap = on_w & alt & bankable_w & phase_q;

  // divider and phase toggle
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 19'h00000;
      phase_q <= 1'b0;
      rate_q <= `LCDSC_RATE_OFF;
      lp_q <= 1'b0;
    end else begin
      rate_q <= rate;
      lp_q <= low_power;
      if (cfg_chg_w | ~on_w) begin
        cnt_q <= 19'h00000;
        phase_q <= 1'b0;
      end else if (cnt_q == half_w) begin
        cnt_q <= 19'h00000;
        phase_q <= ~phase_q;
      end else begin
        cnt_q <= cnt_q + 19'h00001;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_command_a_off_quiet: assert property (!on_w |=> !blank && !swap)
    else $error("command_a active with rate off");
  chk_no_alt_mux: assert property (!bankable_w |-> !swap)
    else $error("bank swap in 1:3 or 1:4 drive");
  chk_phase_at_half: assert property ($changed(phase_q) && $past(on_w) && !$past(cfg_chg_w)
                                      |-> $past(cnt_q) == $past(half_w))
    else $error("command_a phase flipped off the divisor");
  chk_swap_follows_phase: assert property (on_w && alt && bankable_w |-> swap == phase_q && !blank)
    else $error("alternation does not follow command_a phase");
endmodule

// *** dv/lcdsc_bus_master.sv ***
// two-wire bus master model for the serial port
`timescale 1ns/100ps
module lcdsc_bus_master (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  // idle bus: both lines released high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // wait k core cycles, then move just after the edge
  task automatic hold(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // release scl, wait out any stretch, then keep the high phase
  task automatic rise();
    int n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 4000) begin
      hold(1);
      n++;
    end
    hold(10);
  endtask
  // sda falls while scl is high
  task automatic start();
    sda_low = 1'b1;
    hold(10);
    scl_low = 1'b1;
  endtask
  // eight bits msb first, data moves only while scl is low
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      hold(3);
      sda_low = ~b[i];
      hold(10);
      rise();
      scl_low = 1'b1;
    end
    // ninth pulse with sda released, ack read late in the high phase
    hold(3);
    sda_low = 1'b0;
    hold(10);
    rise();
    ack = (sda === 1'b0);
    scl_low = 1'b1;
  endtask
  // sda rises while scl is high
  task automatic stop();
    hold(3);
    sda_low = 1'b1;
    hold(10);
    rise();
    sda_low = 1'b0;
    hold(10);
  endtask
endmodule

// *** dv/lcd_serial_command_blinker_tb_top.sv ***
// self-checking bench for the serial front end and blinker
`timescale 1ns/100ps
module lcd_serial_command_blinker_tb_top;
  logic clk, rst, strap, wr_ready, stretched;
  logic [2:0] sub;
  logic scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda, wr_valid, wr_bank, bias, lp, disp, obank;
  logic [7:0] wr_data;
  logic [5:0] wr_addr;
  logic [1:0] wr_mode, dmode;
  logic [16:0] got[$];
  int err_total, samples_checked, cyc;
  // short command_a divisors so every rate fits in the run
  localparam int DN2 = 16, DN1 = 32, DN05 = 64, DP2 = 8, DP1 = 16, DP05 = 24;
  int divs[6] = '{DN2, DN1, DN05, DP2, DP1, DP05};
  // open-drain wires with pull-ups; a driven line shows the block's output value
  wire scl_w = ~m_scl & (scl_oe ? scl_o : 1'b1);
  wire sda_w = ~m_sda & (sda_oe ? sda_o : 1'b1);
  lcdsc_top #(.DIV_N_2HZ(DN2), .DIV_N_1HZ(DN1), .DIV_N_05HZ(DN05), .DIV_P_2HZ(DP2), .DIV_P_1HZ(DP1),
    .DIV_P_05HZ(DP05)) uut (.CORE_CLK(clk), .RST(rst), .SCL_IN(scl_w), .SCL_OUT(scl_o), .SCL_OE(scl_oe),
    .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE(sda_oe), .ADDRESS_SELECT_STRAP(strap),
    .HW_SUBADDR_BIT0(sub[0]), .HW_SUBADDR_BIT1(sub[1]), .HW_SUBADDR_BIT2(sub[2]),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .WR_ADDR(wr_addr),
    .WR_IN_BANK(wr_bank), .WR_MODE(wr_mode), .DRIVE_MODE(dmode), .BIAS_HALF(bias),
    .LOW_POWER_SELECT(lp), .DISPLAY_ON(disp), .OUT_BANK_SEL(obank));
  lcdsc_bus_master m (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
  // 4 ns core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // collect taken display bytes, cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back({wr_data, wr_addr, wr_bank, wr_mode});
    if (cyc == 80000) begin
      err_total++;
      stop_test();
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  // one transfer; bit i of a is the ack expected for byte i
  task automatic xfer(input logic [7:0] q[$], input logic [15:0] a);
    logic k;
    m.start();
    foreach (q[i]) begin
      m.put(q[i], k);
      chk(k, a[i]);
    end
    m.stop();
  endtask
  // address match by strap, read bit and foreign address refused
  task automatic t_addr();
    xfer('{8'h72, 8'hC9, 8'h49}, 16'h0);
    xfer('{8'h71}, 16'h0);
    strap = 1'b1;
    xfer('{8'h72, 8'h49}, 16'h3);
    strap = 1'b0;
    xfer('{8'h70, 8'hDE, 8'hE0, 8'h74}, 16'hF);
    chk(dmode, 2'h2);
    chk(bias, 1'b1);
    chk(lp, 1'b1);
  endtask
  // data bytes by pointer, stretch while the buffer is full
  task automatic t_data();
    wr_ready = 1'b0;
    stretched = 1'b0;
    got.delete();
    fork
      xfer('{8'h70, 8'hC9, 8'hE0, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44}, 16'hFF);
      begin
        for (int n = 0; n < 3000 && scl_oe !== 1'b1; n++) m.hold(1);
        stretched = scl_oe;
        m.hold(40);
        wr_ready = 1'b1;
      end
    join
    chk(stretched, 1'b1);
    chk(got.size(), 4);
    for (int i = 0; i < got.size(); i++) chk(got[i], {8'(8'h11 * (i + 1)), 6'(8 * i), 1'b0, 2'h1});
    xfer('{8'h70, 8'hE3, 8'h00, 8'h55}, 16'h7);
    chk(got.size(), 4);
    sub = 3'h3;
    xfer('{8'h70, 8'hCA, 8'hFA, 8'hE3, 8'h08, 8'h66, 8'h77}, 16'h7F);
    chk(got.size(), 6);
    chk(got[4], {8'h66, 6'h08, 1'b1, 2'h2});
    chk(got[5], {8'h77, 6'h0C, 1'b1, 2'h2});
    // 1:3 drive at the last word: pointer wraps, subaddress moves on, bank forced off
    xfer('{8'h70, 8'hCB, 8'hE3, 8'h27, 8'h88, 8'h99}, 16'h1F);
    chk(got.size(), 7);
    chk(got[6], {8'h88, 6'h27, 1'b0, 2'h3});
  endtask
  // cycles between two changes of the display enable or bank select
  task automatic half(input bit b, input int e);
    int n = 0;
    logic v;
    v = b ? obank : disp;
    while ((b ? obank : disp) === v && n < 500) begin m.hold(1); n++; end
    v = b ? obank : disp;
    n = 0;
    while ((b ? obank : disp) === v && n < 500) begin m.hold(1); n++; end
    chk(n, e);
  endtask
  // every rate in both power modes, off, alternation
  task automatic t_command_a();
    int n = 0;
    for (int p = 0; p < 2; p++) begin
      for (int r = 1; r < 4; r++) begin
        xfer('{8'h70, 8'(8'hC9 | (p << 4)), 8'(8'h70 | r)}, 16'h7);
        half(1'b0, divs[p * 3 + r - 1] / 2);
      end
    end
    xfer('{8'h70, 8'hC9, 8'h70}, 16'h7);
    for (int i = 0; i < 100; i++) begin m.hold(1); n += (disp !== 1'b1); end
    chk(n, 0);
    xfer('{8'h70, 8'hC9, 8'h75}, 16'h7);
    half(1'b1, DN2 / 2);
    xfer('{8'h70, 8'h48}, 16'h3);
    n = 0;
    for (int i = 0; i < 100; i++) begin m.hold(1); n += (obank !== 1'b0); end
    chk(n, 0);
    // custom-rate blinking by the master: enable off, then on again
    xfer('{8'h70, 8'h40}, 16'h3);
    chk(disp, 1'b0);
    xfer('{8'h70, 8'h48}, 16'h3);
    chk(disp, 1'b1);
  endtask
  // counts, verdict, end of run
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reset for 16 cycles, then the scenarios
  initial begin
    rst = 1'b1;
    strap = 1'b0;
    sub = 3'h0;
    wr_ready = 1'b1;
    stretched = 1'b0;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    m.hold(16);
    rst = 1'b0;
    m.hold(10);
    t_addr();
    t_data();
    t_command_a();
    stop_test();
  end
endmodule
